/* verilog/cmp_input_select_regs.sv */
// comparator input routing and power-down register behind apb
//
// What this block does
// (R1) Bits 31:28 hold comparator b positive select, read/write, reset to zero.
// (R2) Bits 27:24 hold comparator b negative select, one-hot onto analog pins 0 to 3.
// (R3) Bits 23:20 hold comparator a positive select, one-hot onto analog pins 4 to 7.
// (R4) Bits 19:16 hold comparator a negative select, read/write, reset to zero.
// (R5) Software writes only zero or a one-hot code into a select field.
// (R6) Software leaves a select at zero only while that comparator is powered down.
// (R7) Software sets the pin to its analog function before enabling a comparator.
// (R8) Bits 1 and 0 power down comparators b and a, reset to one, zero enables.
// (R9) Hysteresis bits 3:2 and reserved bits 15:4 read as zero and ignore writes.
// (R10) Each stored select drives its mux control output the cycle after the write.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module cmp_input_select_regs (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  output logic [3:0] CMP_B_POSITIVE_SOURCE,
  output logic [3:0] CMP_B_NEGATIVE_SOURCE,
  output logic [3:0] CMP_A_POSITIVE_SOURCE,
  output logic [3:0] CMP_A_NEGATIVE_SOURCE,
  output logic CMP_B_POWER_DOWN,
  output logic CMP_A_POWER_DOWN
);
  import cmp_sel_pkg::*;
  // -----------------------------------------------------------------
  // bus front end
  // -----------------------------------------------------------------
  apb_req_s req;
  logic wr_hit;
  logic [31:0] rd_word;
  logic [15:0] sel_all;
  logic [1:0] pd_q;
  logic [1:0] pd_d;
  cmp_cfg_s cfg;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

  cmp_apb_slave u_bus (
    .CLK(CLK),
    .RST(RST),
    .req(req),
    .rd_word(rd_word),
    .wr_hit(wr_hit),
    .pready_q(PREADY),
    .pslverr_q(PSLVERR),
    .prdata_q(PRDATA)
  );
  // -----------------------------------------------------------------
  // select fields
  // -----------------------------------------------------------------
  // codes are stored as written; reserved codes are not filtered, so the mux
  // control follows software exactly and a bad code stays visible on read-back
  // (R1) (R2) (R3) (R4) four r/w select fields
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sel
      cmp_sel_field u_fld (
        .CLK(CLK),
        .RST(RST),
        .wr_en(wr_hit),
        .wr_val(PWDATA[CMP_A_NEG_LSB + gi*SEL_W +: SEL_W]),
        .sel_q(sel_all[gi*SEL_W +: SEL_W])
      );
    end
  endgenerate
  // -----------------------------------------------------------------
  // power-down bits
  // -----------------------------------------------------------------
  // (R8) pd bits reset to disabled
  always_comb begin
    pd_d = pd_q;
    if (wr_hit) begin
      pd_d = {PWDATA[CMP_B_PD_BIT], PWDATA[CMP_A_PD_BIT]};
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      pd_q <= {PD_RESET, PD_RESET};
    end else begin
      pd_q <= pd_d;
    end
  end
  // -----------------------------------------------------------------
  // read word and mux controls
  // -----------------------------------------------------------------
  // (R9) hysteresis and reserved read zero
  always_comb begin
    rd_word = RDATA_IDLE;
    rd_word[CMP_A_NEG_LSB +: 16] = sel_all;
    rd_word[CMP_B_PD_BIT] = pd_q[1];
    rd_word[CMP_A_PD_BIT] = pd_q[0];
  end
  always_comb begin
    cfg.b_pos = sel_all[15:12];
    cfg.b_neg = sel_all[11:8];
    cfg.a_pos = sel_all[7:4];
    cfg.a_neg = sel_all[3:0];
    cfg.b_pd = pd_q[1];
    cfg.a_pd = pd_q[0];
  end
  // (R10) controls straight from the field flops
  assign CMP_B_POSITIVE_SOURCE = cfg.b_pos;
  assign CMP_B_NEGATIVE_SOURCE = cfg.b_neg;
  assign CMP_A_POSITIVE_SOURCE = cfg.a_pos;
  assign CMP_A_NEGATIVE_SOURCE = cfg.a_neg;
  assign CMP_B_POWER_DOWN = cfg.b_pd;
  assign CMP_A_POWER_DOWN = cfg.a_pd;
  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic past_valid_q;
  logic past_valid_d;
  always_comb begin
    past_valid_d = 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= past_valid_d;
    end
  end

  bpos_write_a: assert property (@(posedge CLK) disable iff (RST) // (R1)
    wr_hit |=> CMP_B_POSITIVE_SOURCE == $past(PWDATA[31:28]))
    else $error("comparator b positive select did not take the write");
  bneg_hold_a: assert property (@(posedge CLK) disable iff (RST) // (R2)
    past_valid_q && !$past(wr_hit) |-> $stable(CMP_B_NEGATIVE_SOURCE))
    else $error("comparator b negative select changed without a write");
  apos_write_a: assert property (@(posedge CLK) disable iff (RST) // (R3)
    wr_hit |=> CMP_A_POSITIVE_SOURCE == $past(PWDATA[23:20]))
    else $error("comparator a positive select did not take the write");
  aneg_reset_a: assert property (@(posedge CLK) // (R4)
    RST |=> CMP_A_NEGATIVE_SOURCE == 4'h0 && CMP_B_POSITIVE_SOURCE == 4'h0)
    else $error("select fields not cleared by reset");
  pd_reset_a: assert property (@(posedge CLK) // (R8)
    RST |=> CMP_A_POWER_DOWN && CMP_B_POWER_DOWN)
    else $error("power-down bits not set by reset");
  pd_write_a: assert property (@(posedge CLK) disable iff (RST) // (R8)
    wr_hit |=> CMP_B_POWER_DOWN == $past(PWDATA[1]) && CMP_A_POWER_DOWN == $past(PWDATA[0]))
    else $error("power-down bits did not take the write");
  reserved_zero_a: assert property (@(posedge CLK) disable iff (RST) // (R9)
    PREADY |-> PRDATA[15:2] == 14'h0000)
    else $error("reserved or hysteresis bits read nonzero");
  readback_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSEL && PENABLE && !PWRITE && !PREADY && PADDR == ANALOG_COMPARATOR_CONFIG_OFS
    |=> PRDATA[31:16] == {CMP_B_POSITIVE_SOURCE, CMP_B_NEGATIVE_SOURCE,
                          CMP_A_POSITIVE_SOURCE, CMP_A_NEGATIVE_SOURCE})
    else $error("read data does not match the mux controls");

  // -----------------------------------------------------------------
  // bus answer checks
  // -----------------------------------------------------------------
  // (R10) one wait state
  ready_wait_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSEL && PENABLE && !PREADY
    |=> PREADY)
    else $error("no answer in the second access cycle");

  // (R10) answer lasts one cycle
  ready_pulse_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PREADY
    |=> !PREADY)
    else $error("ready stood for more than one cycle");

  // (R10) no unasked answer
  ready_idle_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    !(PSEL && PENABLE)
    |=> !PREADY)
    else $error("ready raised outside an access phase");

  // (R10) error only with answer
  err_ready_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSLVERR
    |-> PREADY)
    else $error("error flag raised without ready");

  // (R10) unmapped access refused
  err_unmapped_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSEL && PENABLE && !PREADY && PADDR != ANALOG_COMPARATOR_CONFIG_OFS
    |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused with zero data");

  // (R10) mapped access accepted
  err_mapped_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSEL && PENABLE && !PREADY && PADDR == ANALOG_COMPARATOR_CONFIG_OFS
    |=> !PSLVERR)
    else $error("mapped access answered with an error");

  // (R9) read bus quiet between answers
  rdata_idle_a: assert property (@(posedge CLK) disable iff (RST) // (R9)
    !PREADY
    |-> PRDATA == 32'h0000_0000)
    else $error("read data nonzero outside an answer");

  // (R9) writes return no data
  wdata_quiet_a: assert property (@(posedge CLK) disable iff (RST) // (R9)
    PSEL && PENABLE && PWRITE && !PREADY
    |=> PRDATA == 32'h0000_0000)
    else $error("write answer carried read data");

  // (R10) bus answer reset
  bus_reset_a: assert property (@(posedge CLK) // (R10)
    RST
    |=> !PREADY && !PSLVERR && PRDATA == 32'h0000_0000)
    else $error("bus answer not cleared by reset");

  // -----------------------------------------------------------------
  // field checks
  // -----------------------------------------------------------------
  // (R2) negative select write
  bneg_write_a: assert property (@(posedge CLK) disable iff (RST) // (R2)
    wr_hit
    |=> CMP_B_NEGATIVE_SOURCE == $past(PWDATA[27:24]))
    else $error("comparator b negative select did not take the write");

  // (R4) negative select write
  aneg_write_a: assert property (@(posedge CLK) disable iff (RST) // (R4)
    wr_hit
    |=> CMP_A_NEGATIVE_SOURCE == $past(PWDATA[19:16]))
    else $error("comparator a negative select did not take the write");

  // (R2) negative select reset
  bneg_reset_a: assert property (@(posedge CLK) // (R2)
    RST
    |=> CMP_B_NEGATIVE_SOURCE == 4'h0)
    else $error("comparator b negative select not cleared by reset");

  // (R3) positive select reset
  apos_reset_a: assert property (@(posedge CLK) // (R3)
    RST
    |=> CMP_A_POSITIVE_SOURCE == 4'h0)
    else $error("comparator a positive select not cleared by reset");

  // (R1) positive select holds
  bpos_hold_a: assert property (@(posedge CLK) disable iff (RST) // (R1)
    past_valid_q && !$past(wr_hit)
    |-> $stable(CMP_B_POSITIVE_SOURCE))
    else $error("comparator b positive select changed without a write");

  // (R3) positive select holds
  apos_hold_a: assert property (@(posedge CLK) disable iff (RST) // (R3)
    past_valid_q && !$past(wr_hit)
    |-> $stable(CMP_A_POSITIVE_SOURCE))
    else $error("comparator a positive select changed without a write");

  // (R4) negative select holds
  aneg_hold_a: assert property (@(posedge CLK) disable iff (RST) // (R4)
    past_valid_q && !$past(wr_hit)
    |-> $stable(CMP_A_NEGATIVE_SOURCE))
    else $error("comparator a negative select changed without a write");

  // (R8) power-down bits hold
  pd_hold_a: assert property (@(posedge CLK) disable iff (RST) // (R8)
    past_valid_q && !$past(wr_hit)
    |-> $stable(CMP_B_POWER_DOWN) && $stable(CMP_A_POWER_DOWN))
    else $error("power-down bits changed without a write");

  // (R8) power-down read-back
  pd_readback_a: assert property (@(posedge CLK) disable iff (RST) // (R8)
    PSEL && PENABLE && !PWRITE && !PREADY && PADDR == ANALOG_COMPARATOR_CONFIG_OFS
    |=> PRDATA[1:0] == {CMP_B_POWER_DOWN, CMP_A_POWER_DOWN})
    else $error("power-down bits read back wrong");

  // (R9) hysteresis reads zero
  hyst_zero_a: assert property (@(posedge CLK) disable iff (RST) // (R9)
    PREADY
    |-> PRDATA[3:2] == 2'h0)
    else $error("hysteresis bits read nonzero");

  // -----------------------------------------------------------------
  // no stray stores
  // -----------------------------------------------------------------
  // a refused write must not touch a field, or a bad address could enable a comparator
  // (R10) unmapped write ignored
  unmapped_keep_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSEL && PENABLE && PREADY && PADDR != ANALOG_COMPARATOR_CONFIG_OFS
    |=> $stable(CMP_B_POSITIVE_SOURCE) && $stable(CMP_A_NEGATIVE_SOURCE)
      && $stable(CMP_B_POWER_DOWN) && $stable(CMP_A_POWER_DOWN))
    else $error("unmapped write changed a mux control");

  // (R10) no store before ready
  early_keep_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    PSEL && PENABLE && !PREADY
    |=> $stable(CMP_B_NEGATIVE_SOURCE) && $stable(CMP_A_POSITIVE_SOURCE))
    else $error("a field changed before the answer");

  // (R1) reads store nothing
  read_keep_a: assert property (@(posedge CLK) disable iff (RST) // (R1)
    PSEL && PENABLE && !PWRITE
    |=> $stable(CMP_B_POSITIVE_SOURCE) && $stable(CMP_A_POSITIVE_SOURCE))
    else $error("a read changed a select field");

  // (R10) idle bus stores nothing
  idle_keep_a: assert property (@(posedge CLK) disable iff (RST) // (R10)
    !PSEL
    |=> $stable(CMP_B_NEGATIVE_SOURCE) && $stable(CMP_A_NEGATIVE_SOURCE))
    else $error("a select field changed while the bus was idle");
endmodule

/* verilog/cmp_sel_pkg.sv */
// shared offsets, field layout and reset values of the comparator input select register
package cmp_sel_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [11:0] ANALOG_COMPARATOR_CONFIG_OFS = 12'h00C;
  localparam int ADDR_W = 12;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CMP_B_POS_LSB = 28;
  localparam int CMP_B_NEG_LSB = 24;
  localparam int CMP_A_POS_LSB = 20;
  localparam int CMP_A_NEG_LSB = 16;
  localparam int CMP_B_PD_BIT = 1;
  localparam int CMP_A_PD_BIT = 0;
  localparam int SEL_W = 4;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic PD_RESET = 1'b1;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [3:0] b_pos;
    logic [3:0] b_neg;
    logic [3:0] a_pos;
    logic [3:0] a_neg;
    logic b_pd;
    logic a_pd;
  } cmp_cfg_s;
endpackage

/* verilog/cmp_sel_field.sv */
// one 4-bit select field held in a register, any code stored as written
`timescale 1ns/10ps
module cmp_sel_field (
  input wire logic CLK,
  input wire logic RST,
  input wire logic wr_en,
  input wire logic [3:0] wr_val,
  output logic [3:0] sel_q
);
  import cmp_sel_pkg::*;
  logic [3:0] sel_d;
  always_comb begin
    sel_d = wr_en ? wr_val : sel_q;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      sel_q <= SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end
endmodule

/* verilog/cmp_apb_slave.sv */
// apb slave front end: decodes the single config word, answers with one wait state
`timescale 1ns/10ps
module cmp_apb_slave (
  input wire logic CLK,
  input wire logic RST,
  input wire cmp_sel_pkg::apb_req_s req,
  input wire logic [31:0] rd_word,
  output logic wr_hit,
  output logic pready_q,
  output logic pslverr_q,
  output logic [31:0] prdata_q
);
  import cmp_sel_pkg::*;
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_d;
  logic hit;
  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  always_comb begin
    hit = (req.paddr == ANALOG_COMPARATOR_CONFIG_OFS);
    // answer in the second access cycle; pready_q low in the first means a new access
    pready_d = req.psel && req.penable && !pready_q;
    pslverr_d = pready_d && !hit;
    prdata_d = RDATA_IDLE;
    if (pready_d && !req.pwrite && hit) begin
      prdata_d = rd_word;
    end
  end
  // write lands at the edge where the master sees pready high
  assign wr_hit = req.psel && req.penable && pready_q && req.pwrite && hit;
  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RDATA_IDLE;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end
endmodule

/* test/comparator_input_select_regs_bench.sv */
// self-checking bench for the comparator input select register over apb
`timescale 1ns/10ps
module comparator_input_select_regs_bench;
  import cmp_sel_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic PREADY, PSLVERR;
  logic [31:0] PRDATA;
  logic [3:0] b_pos, b_neg, a_pos, a_neg;
  logic b_pd, a_pd;
  logic [31:0] outs, rd;
  logic err;
  logic [3:0] c, r;
  int fail_count = 0;
  int checks_done = 0;

  assign outs = {b_pos, b_neg, a_pos, a_neg, 14'h0000, b_pd, a_pd};
  always #20 CLK = ~CLK;

  cmp_input_select_regs dut_u (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PRDATA(PRDATA), .CMP_B_POSITIVE_SOURCE(b_pos), .CMP_B_NEGATIVE_SOURCE(b_neg),
    .CMP_A_POSITIVE_SOURCE(a_pos), .CMP_A_NEGATIVE_SOURCE(a_neg),
    .CMP_B_POWER_DOWN(b_pd), .CMP_A_POWER_DOWN(a_pd)
  );

  // -----------------------------------------------------------------
  // checking and verdict
  // -----------------------------------------------------------------
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // apb master: request held until pready is seen at a rising edge
  // -----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // write then look at the mux outputs once the store has landed
  task automatic wr_chk(input logic [31:0] d, input logic [31:0] exp);
    apb(1'b1, ANALOG_COMPARATOR_CONFIG_OFS, d);
    @(negedge CLK);
    compare(outs, exp & 32'hFFFF_0003);
    compare({31'h0, err}, 32'h0000_0000);
    apb(1'b0, ANALOG_COMPARATOR_CONFIG_OFS, 32'h0000_0000);
    compare(rd, exp);
  endtask

  initial begin
    repeat (3000) @(posedge CLK);
    fail_count++;
    print_verdict();
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    compare(outs, 32'h0000_0003);
    apb(1'b0, ANALOG_COMPARATOR_CONFIG_OFS, 32'h0000_0000);
    compare(rd, 32'h0000_0003);
    // reserved and hysteresis bits ignore ones; legal codes while both are powered down
    wr_chk(32'h8888_FFFF, 32'h8888_0003);
    // every one-hot code in every field; analog pins taken as set up before any enable
    for (int i = 0; i < 4; i++) begin
      c = 4'h1 << i;
      r = 4'h8 >> i;
      wr_chk({c, r, c, r, 16'hFFFC}, {c, r, c, r, 16'h0000});
    end
    wr_chk(32'h1248_0002, 32'h1248_0002);
    // unmapped place: refused, nothing stored, reads zero
    apb(1'b1, 12'h010, 32'h8888_0001);
    compare({31'h0, err}, 32'h0000_0001);
    @(negedge CLK);
    compare(outs, 32'h1248_0002);
    apb(1'b0, 12'h010, 32'h0000_0000);
    compare(rd, 32'h0000_0000);
    compare({31'h0, err}, 32'h0000_0001);
    // second reset in mid-run returns the power-on state
    @(posedge CLK);
    RST <= 1'b1;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    compare(outs, 32'h0000_0003);
    print_verdict();
  end
endmodule
